// >>> src/srcd_top.sv
// Sample rate clock divider with data ready pulse and correction registers
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`include "srcd_regs.svh"
module srcd_top
   import srcd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_mod0,
   input wire logic i_mod1,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic o_result_ready_n,
   output logic o_result_ready_oe,
   output logic o_digital_sample_clock,
   output logic o_output_rate_clock
);
   function automatic logic [31:0] srcd_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) m[b*8 +: 8] = d[b*8 +: 8];
      end
      return m;
   endfunction

   logic [1:0] prescale_select_r;
   logic [2:0] decimation_ratio_select_r;
   logic ready_pin_drive_select_r;
   srcd_word_t offset0_r, offset1_r, gain0_r, gain1_r;

   // Prescale counter: tick every 1, 2, 4 or 8 input clocks
   logic [2:0] pre_cnt_r;
   logic [2:0] pre_max;
   logic pre_tick;
   assign pre_max = 3'((4'h1 << prescale_select_r) - 4'h1);
   assign pre_tick = (pre_cnt_r == pre_max);
   logic [1:0] div4_cnt_r;
   logic sample_tick;
   assign sample_tick = pre_tick && (div4_cnt_r == 2'(`SRCD_SAMPLE_DIV - 1));
   logic [11:0] osr_cnt_r;
   logic [11:0] osr_max;
   logic rate_tick;
   assign osr_max = 12'((13'h1 << (`SRCD_OSR_MIN_LOG2 + decimation_ratio_select_r))
                        - 13'h1);
   assign rate_tick = sample_tick && (osr_cnt_r >= osr_max);

   // Pulse stays low from one output tick to the next sample tick
   logic pulse_r;
   logic [1:0] osr_latched_r;

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pre_cnt_r <= 3'h0;
         div4_cnt_r <= 2'h0;
         osr_cnt_r <= 12'h000;
      end else begin
         pre_cnt_r <= pre_tick ? 3'h0 : pre_cnt_r + 3'h1;
         if (pre_tick) div4_cnt_r <= div4_cnt_r + 2'h1;
         if (sample_tick) osr_cnt_r <= rate_tick ? 12'h000 : osr_cnt_r + 12'h001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pulse_r <= 1'b0;
      end else if (rate_tick) begin
         pulse_r <= 1'b1;
      end else if (sample_tick) begin
         pulse_r <= 1'b0;
      end
   end

   // Sinc1 decimator: boxcar sum over OSR samples nulls every rate multiple
   logic [23:0] acc0_r, acc1_r, raw0_r, raw1_r;
   logic [23:0] acc0_step, acc1_step;
   assign acc0_step = i_mod0 ? 24'h000001 : 24'hffffff;
   assign acc1_step = i_mod1 ? 24'h000001 : 24'hffffff;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         acc0_r <= 24'h000000;
         acc1_r <= 24'h000000;
         raw0_r <= 24'h000000;
         raw1_r <= 24'h000000;
      end else if (sample_tick) begin
         acc0_r <= rate_tick ? 24'h000000 : acc0_r + acc0_step;
         acc1_r <= rate_tick ? 24'h000000 : acc1_r + acc1_step;
         if (rate_tick) begin
            raw0_r <= acc0_r + acc0_step;
            raw1_r <= acc1_r + acc1_step;
         end
      end
   end
   logic load_r;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) load_r <= 1'b0;
      else load_r <= rate_tick && sample_tick;
   end
   logic [23:0] result0, result1;
   srcd_corr u_corr0 (.i_clk(i_clk), .i_resetn(i_resetn), .i_load(load_r), .i_raw(raw0_r),
                      .i_offset(offset0_r), .i_gain(gain0_r), .o_result(result0));
   srcd_corr u_corr1 (.i_clk(i_clk), .i_resetn(i_resetn), .i_load(load_r), .i_raw(raw1_r),
                      .i_offset(offset1_r), .i_gain(gain1_r), .o_result(result1));

   // Pin outputs, registered
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_result_ready_n <= 1'b1;
         o_result_ready_oe <= 1'b0;
         o_digital_sample_clock <= 1'b0;
         o_output_rate_clock <= 1'b0;
         osr_latched_r <= 2'h0;
      end else begin
         o_result_ready_n <= ~pulse_r;
         o_result_ready_oe <= pulse_r | ready_pin_drive_select_r;
         o_digital_sample_clock <= div4_cnt_r[1];
         o_output_rate_clock <= (osr_cnt_r > (osr_max >> 1));
         osr_latched_r <= {osr_latched_r[0], pulse_r};
      end
   end

   // AXI4-Lite write: address and data taken in either order, then response
   logic aw_have_r, w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_write;
   logic [7:0] wa;
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wa = aw_addr_r;
   logic wr_ok;
   assign wr_ok = (wa == `SRCD_ADDR_CONFIG) || (wa == `SRCD_ADDR_OFFSET0) ||
                  (wa == `SRCD_ADDR_GAIN0) || (wa == `SRCD_ADDR_OFFSET1) ||
                  (wa == `SRCD_ADDR_GAIN1);
   logic [31:0] cfg_word;
   assign cfg_word = {26'h0, ready_pin_drive_select_r, decimation_ratio_select_r,
                      prescale_select_r};
   logic [31:0] cfg_new;
   assign cfg_new = srcd_merge(cfg_word, w_data_r, w_strb_r);

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Ready is the registered image of the next channel state, so it shows no glitch
   logic aw_have_nxt, w_have_nxt, bvalid_nxt;
   assign aw_have_nxt = !do_write && ((s_axi_awvalid && s_axi_awready) || aw_have_r);
   assign w_have_nxt = !do_write && ((s_axi_wvalid && s_axi_wready) || w_have_r);
   assign bvalid_nxt = do_write || (s_axi_bvalid && !s_axi_bready);
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
         s_axi_wready <= !w_have_nxt && !bvalid_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         prescale_select_r <= `SRCD_PRE_RESET;
         decimation_ratio_select_r <= `SRCD_OSR_RESET;
         ready_pin_drive_select_r <= `SRCD_DRV_RESET;
         offset0_r <= 24'h000000;
         offset1_r <= 24'h000000;
         gain0_r <= `SRCD_GAIN_UNITY;
         gain1_r <= `SRCD_GAIN_UNITY;
      end else if (do_write) begin
         case (wa)
            `SRCD_ADDR_CONFIG: begin
               prescale_select_r <= cfg_new[`SRCD_CFG_PRE_LSB +: 2];
               decimation_ratio_select_r <= cfg_new[`SRCD_CFG_OSR_LSB +: 3];
               ready_pin_drive_select_r <= cfg_new[`SRCD_CFG_DRV_BIT];
            end
            `SRCD_ADDR_OFFSET0:
               offset0_r <= 24'(srcd_merge({8'h0, offset0_r}, w_data_r, w_strb_r));
            `SRCD_ADDR_GAIN0: gain0_r <= 24'(srcd_merge({8'h0, gain0_r}, w_data_r, w_strb_r));
            `SRCD_ADDR_OFFSET1:
               offset1_r <= 24'(srcd_merge({8'h0, offset1_r}, w_data_r, w_strb_r));
            `SRCD_ADDR_GAIN1: gain1_r <= 24'(srcd_merge({8'h0, gain1_r}, w_data_r, w_strb_r));
            default: begin
            end
         endcase
      end
   end

   // AXI4-Lite read: one-cycle registered answer
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_mux = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `SRCD_ADDR_CONFIG: rd_mux = cfg_word;
         `SRCD_ADDR_STATUS: rd_mux = {30'h0, osr_latched_r[1], pulse_r};
         `SRCD_ADDR_OFFSET0: rd_mux = {8'h00, offset0_r};
         `SRCD_ADDR_GAIN0: rd_mux = {8'h00, gain0_r};
         `SRCD_ADDR_OFFSET1: rd_mux = {8'h00, offset1_r};
         `SRCD_ADDR_GAIN1: rd_mux = {8'h00, gain1_r};
         `SRCD_ADDR_SAMPLE0: rd_mux = {20'h0, osr_cnt_r};
         `SRCD_ADDR_SAMPLE1: rd_mux = {30'h0, div4_cnt_r};
         `SRCD_ADDR_RESULT0: rd_mux = {8'h00, result0};
         `SRCD_ADDR_RESULT1: rd_mux = {8'h00, result1};
         default: rd_ok = 1'b0;
      endcase
   end
   logic arready_nxt;
   assign arready_nxt = !(s_axi_arvalid && s_axi_arready) && (s_axi_rready || !s_axi_rvalid);
   always_ff @(posedge i_clk) begin
      if (!i_resetn) s_axi_arready <= 1'b1;
      else s_axi_arready <= arready_nxt;
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> src/srcd_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SRCD_REGS_SVH
`define SRCD_REGS_SVH
`define SRCD_ADDR_CONFIG 8'h00
`define SRCD_ADDR_STATUS 8'h04
`define SRCD_ADDR_OFFSET0 8'h08
`define SRCD_ADDR_GAIN0 8'h0c
`define SRCD_ADDR_OFFSET1 8'h10
`define SRCD_ADDR_GAIN1 8'h14
`define SRCD_ADDR_SAMPLE0 8'h18
`define SRCD_ADDR_SAMPLE1 8'h1c
`define SRCD_ADDR_RESULT0 8'h20
`define SRCD_ADDR_RESULT1 8'h24
`define SRCD_CFG_PRE_LSB 0
`define SRCD_CFG_OSR_LSB 2
`define SRCD_CFG_DRV_BIT 5
`define SRCD_PRE_RESET 2'h0
`define SRCD_OSR_RESET 3'h3
`define SRCD_DRV_RESET 1'b0
`define SRCD_OSR_MIN_LOG2 5
`define SRCD_SAMPLE_DIV 4
`define SRCD_GAIN_UNITY 24'h400000
`endif

// >>> src/srcd_pkg.sv
// Types shared by the clock divider block
package srcd_pkg;
   typedef enum logic [1:0] {
      SRCD_IDLE = 2'b00,
      SRCD_ADDR = 2'b01,
      SRCD_RESP = 2'b11
   } srcd_wstate_t;
   typedef logic [23:0] srcd_word_t;
endpackage

// >>> src/srcd_corr.sv
// Offset and gain correction of one channel's filter result
module srcd_corr
   import srcd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_load,
   input wire logic [23:0] i_raw,
   input wire logic [23:0] i_offset,
   input wire logic [23:0] i_gain,
   output logic [23:0] o_result
);
   // Gain is signed Q1.22: unity is 0x400000
   logic signed [24:0] sum;
   logic signed [48:0] prod;
   logic [23:0] result_r;
   assign sum = $signed({i_raw[23], i_raw}) + $signed({i_offset[23], i_offset});
   assign prod = sum * $signed(i_gain);
   assign o_result = result_r;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         result_r <= 24'h000000;
      end else if (i_load) begin
         result_r <= prod[45:22];
      end
   end
endmodule

// >>> verif/srcd_sva.sv
// Checker for the ready pulse, the divided clocks and the bus handshakes
module srcd_sva (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic o_result_ready_n,
   input wire logic o_result_ready_oe,
   input wire logic o_digital_sample_clock,
   input wire logic o_output_rate_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sq_r;
   logic [15:0] sc_r;
   logic [15:0] per_r;
   logic [15:0] lc_r;
   wire rise = o_digital_sample_clock && !sq_r;
   // Pulse width is judged against the measured sample period, so every prescale works
   always_ff @(posedge i_clk) begin
      sq_r <= o_digital_sample_clock;
      sc_r <= rise ? 16'h1 : sc_r + 16'h1;
      if (rise) per_r <= sc_r;
      lc_r <= o_result_ready_n ? 16'h0 : lc_r + 16'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_width; $rose(o_result_ready_n) |-> lc_r == per_r; endproperty
   a_width: assert property (p_width) else $error("ready pulse width wrong");
   property p_min; $fell(o_result_ready_n) |=> !o_result_ready_n [*3]; endproperty
   a_min: assert property (p_min) else $error("ready pulse too short");
   property p_oe; !o_result_ready_n |-> o_result_ready_oe; endproperty
   a_oe: assert property (p_oe) else $error("pulse not driven");
   property p_rate; $fell(o_output_rate_clock) |-> ##[0:3] !o_result_ready_n; endproperty
   a_rate: assert property (p_rate) else $error("rate tick without pulse");
   property p_half; $changed(o_digital_sample_clock) |=> $stable(o_digital_sample_clock);
   endproperty
   a_half: assert property (p_half) else $error("sample clock half too short");
   property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("read taken while answering");
   c_pulse: cover property ($fell(o_result_ready_n));
   c_write: cover property (s_axi_bvalid);
   c_read: cover property (s_axi_rvalid);
endmodule
bind srcd_top srcd_sva u_sva (.i_clk, .i_resetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .o_result_ready_n, .o_result_ready_oe, .o_digital_sample_clock,
   .o_output_rate_clock);

// >>> verif/srcd_host.sv
// Host interrupt input that times the low pulses seen on the ready wire
module srcd_host (
   input wire logic i_clk,
   input wire logic i_pin,
   output int o_falls,
   output int o_gap,
   output int o_width
);
   timeunit 1ns;
   timeprecision 1ps;
   int t = 0;
   int tf = 0;
   logic last = 1'b1;
   initial begin
      o_falls = 0;
      o_gap = 0;
      o_width = 0;
   end
   // Edges are seen on clock samples, as a synchronous interrupt input would see them
   always @(posedge i_clk) begin
      t <= t + 1;
      last <= i_pin;
      if (!i_pin && last) begin
         o_gap <= t - tf;
         tf <= t;
         o_falls <= o_falls + 1;
      end
      if (i_pin && !last) o_width <= t - tf;
   end
endmodule

// >>> verif/sample_rate_clock_divider_bench.sv
// Bench for the sample rate clock divider
`include "srcd_regs.svh"
module sample_rate_clock_divider_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [5:0] c; logic [31:0] g; logic [31:0] w;} srcd_row_t;
   srcd_row_t rows [8] = '{'{6'h00, 32'h80, 32'h4}, '{6'h05, 32'h200, 32'h8},
      '{6'h0a, 32'h800, 32'h10}, '{6'h03, 32'h400, 32'h20}, '{6'h10, 32'h800, 32'h4},
      '{6'h14, 32'h1000, 32'h4}, '{6'h18, 32'h2000, 32'h4}, '{6'h1c, 32'h4000, 32'h4}};
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ready_n, oe, sclk, rate;
   logic [1:0] bresp, rresp, r;
   int fail_count = 0, checks = 0, cyc = 0, falls, gap, width, f;
   // The wire has a pull-up, so a released pin reads high
   wire pin = oe ? ready_n : 1'b1;
   srcd_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_mod0(1'b1), .i_mod1(1'b0),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .o_result_ready_n(ready_n),
      .o_result_ready_oe(oe), .o_digital_sample_clock(sclk), .o_output_rate_clock(rate));
   srcd_host host (.i_clk(i_clk), .i_pin(pin), .o_falls(falls), .o_gap(gap),
      .o_width(width));
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         r = bresp;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (arready) arvalid <= 1'b0;
         d = rdata;
         r = rresp;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wf();
      f = falls;
      while (falls == f) @(posedge i_clk);
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 100000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      chk(ready_n, 32'h1);
      chk(oe, 32'h0);
      repeat (1000) @(posedge i_clk);
      chk(falls, 32'h0);
      repeat (40) @(posedge i_clk);
      chk(falls, 32'h1);
      rd(`SRCD_ADDR_CONFIG);
      chk(d, 32'hc);
      rd(`SRCD_ADDR_GAIN1);
      chk(d, 32'h400000);
      rd(8'h40);
      chk(r, 32'h2);
      chk(d, 32'h0);
      wr(`SRCD_ADDR_STATUS, 32'h3);
      chk(r, 32'h2);
      wf();
      chk(gap, 32'h400);
      chk(width, 32'h4);
      // Config is written once a pulse has ended, so no pulse in flight is cut short
      foreach (rows[i]) begin
         while (!pin) @(posedge i_clk);
         wr(`SRCD_ADDR_CONFIG, {26'h0, rows[i].c});
         wf();
         wf();
         chk(gap, rows[i].g);
         chk(width, rows[i].w);
      end
      wr(`SRCD_ADDR_OFFSET0, 32'h10);
      chk(r, 32'h0);
      wr(`SRCD_ADDR_GAIN0, 32'h200000);
      wr(`SRCD_ADDR_CONFIG, 32'h20);
      wf();
      wf();
      repeat (10) @(posedge i_clk);
      chk(oe, 32'h1);
      chk(pin, 32'h1);
      rd(`SRCD_ADDR_RESULT0);
      chk(d, 32'h18);
      rd(`SRCD_ADDR_RESULT1);
      chk(d, 32'hffffe0);
      rd(`SRCD_ADDR_OFFSET0);
      chk(d, 32'h10);
      wr(`SRCD_ADDR_CONFIG, 32'h0);
      wf();
      repeat (10) @(posedge i_clk);
      chk(oe, 32'h0);
      chk({31'h0, rate}, 32'h0);
      d = {31'h0, sclk};
      repeat (2) @(posedge i_clk);
      chk({31'h0, sclk}, d ^ 32'h1);
      repeat (60) @(posedge i_clk);
      chk({31'h0, rate}, 32'h1);
      summarize();
   end
endmodule
